/* lpm_core.sv */
// Measurement sequencing and result registers of the light and proximity core
`timescale 1ns/1ns
`include "lpm_consts.svh"
module lpm_core
    import lpm_pkg::*;
#(
    parameter int FINE_UNIT_CYCLES = `LPM_FINE_UNIT_CYCLES,
    parameter int COARSE_UNIT_CYCLES = `LPM_COARSE_UNIT_CYCLES,
    parameter int PROX_ACTIVE_CYCLES = `LPM_PROX_ACTIVE_CYCLES,
    parameter int POR_WAIT_CYCLES = `LPM_POR_WAIT_CYCLES,
    parameter int REPEAT_TICK_CYCLES = `LPM_REPEAT_TICK_CYCLES
)
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic reg_ready,
    input wire logic amb_pulse,
    output logic amb_front_on,
    input wire logic [15:0] prox_raw,
    output logic prox_front_on,
    output logic common_on,
    input wire logic int_request,
    output logic int_o,
    output logic int_oe_n
);

    lpm_state_type st;
    lpm_state_type next_st;
    logic [7:0] prox_code;
    logic [15:0] acc_inc;
    logic [19:0] unit_last;
    logic [7:0] gain_clamped;
    logic amb_go;
    logic prox_go;

    lpm_log_encode u_log
    (
        .raw(prox_raw),
        .code(prox_code)
    );

    always_comb
    begin
        next_st = st;
        acc_inc = st.amb_acc;
        unit_last = st.coarse_used ? 20'(COARSE_UNIT_CYCLES - 1) : 20'(FINE_UNIT_CYCLES - 1);
        gain_clamped = st.gain;
        amb_go = 1'b0;
        prox_go = 1'b0;
        next_st.tick = 1'b0;
        next_st.rdata = 8'h00;

        // Internal reset held until the power-up wait has run out
        if (!st.por_done)
        begin
            if (st.por_cnt == 20'(POR_WAIT_CYCLES - 1))
            begin
                next_st.por_done = 1'b1;
            end
            else
            begin
                next_st.por_cnt = st.por_cnt + 20'h00001;
            end
        end

        if (st.tick_cnt == 20'(REPEAT_TICK_CYCLES - 1))
        begin
            next_st.tick_cnt = 20'h00000;
            next_st.tick = 1'b1;
        end
        else
        begin
            next_st.tick_cnt = st.tick_cnt + 20'h00001;
        end
        // Ticks since each channel last started, saturating
        for (int i = 0; i < 2; i++)
        begin
            if (st.tick && st.rep_cnt[i] != 8'hFF)
            begin
                next_st.rep_cnt[i] = st.rep_cnt[i] + 8'h01;
            end
        end

        if (st.gain < `LPM_GAIN_MIN)
        begin
            gain_clamped = `LPM_GAIN_MIN;
        end
        else if (st.gain > `LPM_GAIN_MAX)
        begin
            gain_clamped = `LPM_GAIN_MAX;
        end

        if (st.por_done && st.amb_en)
        begin
            amb_go = st.forced ? st.trig[0] : (st.rep_cnt[0] >= st.amb_rate);
        end
        if (st.por_done && st.prox_en)
        begin
            prox_go = st.forced ? st.trig[1] : (st.rep_cnt[1] >= st.prox_rate);
        end

        // Ambient sequencer
        case (st.amb_state)
            LPM_AMB_IDLE:
            begin
                if (amb_go)
                begin
                    next_st.amb_state = LPM_AMB_INTEG;
                    next_st.gain_used = gain_clamped;
                    next_st.coarse_used = st.coarse;
                    next_st.amb_pre = 20'h00000;
                    next_st.amb_step = 8'h00;
                    next_st.amb_acc = 16'h0000;
                    next_st.rep_cnt[0] = 8'h00;
                    next_st.trig[0] = 1'b0;
                end
            end
            LPM_AMB_INTEG:
            begin
                // Raw count kept as is; its weight is 53/gain lux
                if (amb_pulse && st.amb_acc != 16'hFFFF)
                begin
                    acc_inc = st.amb_acc + 16'h0001;
                end
                next_st.amb_acc = acc_inc;
                if (st.amb_pre == unit_last)
                begin
                    next_st.amb_pre = 20'h00000;
                    if (st.amb_step == st.gain_used - 8'h01)
                    begin
                        next_st.amb_res = acc_inc;
                        next_st.amb_state = LPM_AMB_IDLE;
                    end
                    else
                    begin
                        next_st.amb_step = st.amb_step + 8'h01;
                    end
                end
                else
                begin
                    next_st.amb_pre = st.amb_pre + 20'h00001;
                end
            end
            default:
            begin
                next_st.amb_state = LPM_AMB_IDLE;
            end
        endcase

        // Proximity sequencer
        case (st.prox_state)
            LPM_PROX_IDLE:
            begin
                if (prox_go)
                begin
                    next_st.prox_state = LPM_PROX_ACTIVE;
                    next_st.prox_cnt = 20'h00000;
                    next_st.rep_cnt[1] = 8'h00;
                    next_st.trig[1] = 1'b0;
                end
            end
            LPM_PROX_ACTIVE:
            begin
                if (st.prox_cnt == 20'(PROX_ACTIVE_CYCLES - 1))
                begin
                    next_st.prox_res = prox_code;
                    next_st.prox_state = LPM_PROX_IDLE;
                end
                else
                begin
                    next_st.prox_cnt = st.prox_cnt + 20'h00001;
                end
            end
            default:
            begin
                next_st.prox_state = LPM_PROX_IDLE;
            end
        endcase

        // Register reads; a low-byte read freezes the high byte until the next low-byte read
        if (st.por_done && reg_rd)
        begin
            if (reg_addr == `LPM_ADDR_CTRL)
            begin
                next_st.rdata = {2'b00, st.trig, st.coarse, st.forced, st.prox_en, st.amb_en};
            end
            else if (reg_addr == `LPM_ADDR_STATUS)
            begin
                next_st.rdata = {5'h00, st.common_on, st.prox_state, st.amb_state};
            end
            else if (reg_addr == `LPM_ADDR_AMB_RATE)
            begin
                next_st.rdata = st.amb_rate;
            end
            else if (reg_addr == `LPM_ADDR_PROX_RATE)
            begin
                next_st.rdata = st.prox_rate;
            end
            else if (reg_addr == `LPM_ADDR_AMB_LOW)
            begin
                next_st.rdata = st.amb_res[7:0];
                next_st.high_shadow = st.amb_res[15:8];
            end
            else if (reg_addr == `LPM_ADDR_AMB_HIGH)
            begin
                next_st.rdata = st.high_shadow;
            end
            else if (reg_addr == `LPM_ADDR_PROX)
            begin
                next_st.rdata = st.prox_res;
            end
            else if (reg_addr == `LPM_ADDR_INT_CFG)
            begin
                next_st.rdata = {3'b000, st.int_cfg};
            end
            else if (reg_addr == `LPM_ADDR_GAIN)
            begin
                next_st.rdata = st.gain;
            end
        end

        // Register writes come last so a trigger write wins over its consumption
        if (st.por_done && reg_wr)
        begin
            if (reg_addr == `LPM_ADDR_CTRL)
            begin
                next_st.amb_en = reg_wdata[`LPM_CTRL_AMB_EN];
                next_st.prox_en = reg_wdata[`LPM_CTRL_PROX_EN];
                next_st.forced = reg_wdata[`LPM_CTRL_FORCED];
                next_st.coarse = reg_wdata[`LPM_CTRL_COARSE];
                if (reg_wdata[`LPM_CTRL_FORCED])
                begin
                    next_st.trig[0] = next_st.trig[0] | reg_wdata[`LPM_CTRL_AMB_TRIG];
                    next_st.trig[1] = next_st.trig[1] | reg_wdata[`LPM_CTRL_PROX_TRIG];
                end
                else
                begin
                    next_st.trig = 2'b00;
                end
            end
            else if (reg_addr == `LPM_ADDR_AMB_RATE)
            begin
                next_st.amb_rate = reg_wdata;
            end
            else if (reg_addr == `LPM_ADDR_PROX_RATE)
            begin
                next_st.prox_rate = reg_wdata;
            end
            else if (reg_addr == `LPM_ADDR_INT_CFG)
            begin
                next_st.int_cfg = reg_wdata[4:0];
            end
            else if (reg_addr == `LPM_ADDR_GAIN)
            begin
                next_st.gain = reg_wdata;
            end
        end

        // Shared circuitry stays on while any channel or forced mode is set
        next_st.common_on = next_st.por_done
            & (next_st.amb_en | next_st.prox_en | next_st.forced);
        next_st.int_o = 1'b0;
        next_st.int_oe_n = !((st.int_cfg[1:0] != 2'b00) && int_request);
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            st <= '0;
            st.amb_rate <= `LPM_AMB_RATE_RESET;
            st.prox_rate <= `LPM_PROX_RATE_RESET;
            st.gain <= `LPM_GAIN_RESET;
            st.gain_used <= `LPM_GAIN_RESET;
            st.int_cfg <= `LPM_INT_CFG_RESET;
            st.rep_cnt <= {8'hFF, 8'hFF};
            st.int_oe_n <= 1'b1;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign reg_rdata = st.rdata;
    assign reg_ready = st.por_done;
    assign amb_front_on = st.amb_state;
    assign prox_front_on = st.prox_state;
    assign common_on = st.common_on;
    assign int_o = st.int_o;
    assign int_oe_n = st.int_oe_n;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    a_gain_in_window: assert property ($rose(amb_front_on) |-> st.gain_used >= 8'h18 && st.gain_used <= 8'hFE) else $error("gain outside window");
    a_integ_step_end: assert property ($fell(amb_front_on) |-> $past(st.amb_step) == $past(st.gain_used) - 8'h01) else $error("integration ended at wrong step");
    a_result_atomic: assert property ($changed(st.amb_res) |-> $past(st.amb_state) == LPM_AMB_INTEG && st.amb_state == LPM_AMB_IDLE) else $error("ambient result changed outside completion");
    a_prox_active_len: assert property ($fell(prox_front_on) |-> $past(st.prox_cnt) == 20'(PROX_ACTIVE_CYCLES - 1)) else $error("proximity active time wrong");
    a_prox_res_end: assert property ($changed(st.prox_res) |-> $fell(prox_front_on)) else $error("proximity result changed mid measurement");
    a_por_quiet: assert property (!reg_ready |-> !amb_front_on && !prox_front_on && reg_rdata == 8'h00) else $error("activity during power-up wait");
    a_int_released: assert property (st.int_cfg[1:0] == 2'b00 |=> int_oe_n) else $error("interrupt pin driven while unconfigured");
    a_forced_trigger: assert property ($rose(amb_front_on) && $past(st.forced) |-> $past(st.trig[0])) else $error("forced start without trigger");
    a_enable_gate: assert property ($rose(prox_front_on) |-> $past(st.prox_en)) else $error("proximity ran while disabled");
    a_restart_at_once: assert property ($fell(amb_front_on) && st.amb_en && !st.forced && st.rep_cnt[0] >= st.amb_rate |=> amb_front_on) else $error("overdue measurement not restarted");
    a_reset_default: assert property ($rose(resetn) |-> st.gain == 8'h35 && int_oe_n) else $error("reset defaults wrong");

    c_amb_done: cover property ($fell(amb_front_on));
    c_prox_done: cover property ($fell(prox_front_on));
    c_forced_run: cover property (st.forced && $rose(amb_front_on));
    c_back_to_back: cover property ($fell(amb_front_on) ##1 amb_front_on);

endmodule

/* lpm_consts.svh */
// Constants of the light and proximity measurement core
`ifndef LPM_CONSTS_SVH
`define LPM_CONSTS_SVH

`define LPM_CLK_MHZ 100
`define LPM_FINE_INTEG_MS 100
`define LPM_COARSE_INTEG_MS 16
`define LPM_PROX_ACTIVE_US 1400
`define LPM_POR_WAIT_MS 2
`define LPM_REPEAT_TICK_MS 10
`define LPM_GAIN_DEFAULT_DEC 53
`define LPM_FINE_UNIT_CYCLES ((`LPM_FINE_INTEG_MS * 1000 * `LPM_CLK_MHZ) / `LPM_GAIN_DEFAULT_DEC)
`define LPM_COARSE_UNIT_CYCLES ((`LPM_COARSE_INTEG_MS * 1000 * `LPM_CLK_MHZ) / `LPM_GAIN_DEFAULT_DEC)
`define LPM_PROX_ACTIVE_CYCLES (`LPM_PROX_ACTIVE_US * `LPM_CLK_MHZ)
`define LPM_POR_WAIT_CYCLES (`LPM_POR_WAIT_MS * 1000 * `LPM_CLK_MHZ)
`define LPM_REPEAT_TICK_CYCLES (`LPM_REPEAT_TICK_MS * 1000 * `LPM_CLK_MHZ)

`define LPM_ADDR_CTRL 8'h40
`define LPM_ADDR_STATUS 8'h41
`define LPM_ADDR_AMB_RATE 8'h45
`define LPM_ADDR_PROX_RATE 8'h46
`define LPM_ADDR_AMB_LOW 8'h4C
`define LPM_ADDR_AMB_HIGH 8'h4D
`define LPM_ADDR_PROX 8'h4F
`define LPM_ADDR_INT_CFG 8'h52
`define LPM_ADDR_GAIN 8'h5A

`define LPM_CTRL_AMB_EN 0
`define LPM_CTRL_PROX_EN 1
`define LPM_CTRL_FORCED 2
`define LPM_CTRL_COARSE 3
`define LPM_CTRL_AMB_TRIG 4
`define LPM_CTRL_PROX_TRIG 5

`define LPM_GAIN_RESET 8'h35
`define LPM_GAIN_MIN 8'h18
`define LPM_GAIN_MAX 8'hFE
`define LPM_AMB_RATE_RESET 8'h32
`define LPM_PROX_RATE_RESET 8'h0A
`define LPM_INT_CFG_RESET 5'h08
`define LPM_INT_CFG_MASK 8'h1F

`endif

/* lpm_pkg.sv */
// Types of the light and proximity measurement core
package lpm_pkg;

    typedef enum logic [0:0] {
        LPM_AMB_IDLE = 1'b0,
        LPM_AMB_INTEG = 1'b1
    } lpm_amb_state_type;

    typedef enum logic [0:0] {
        LPM_PROX_IDLE = 1'b0,
        LPM_PROX_ACTIVE = 1'b1
    } lpm_prox_state_type;

    typedef struct packed {
        logic [19:0] por_cnt;
        logic por_done;
        logic amb_en;
        logic prox_en;
        logic forced;
        logic coarse;
        logic [1:0] trig;
        logic [7:0] amb_rate;
        logic [7:0] prox_rate;
        logic [4:0] int_cfg;
        logic [7:0] gain;
        logic [19:0] tick_cnt;
        logic tick;
        logic [1:0][7:0] rep_cnt;
        lpm_amb_state_type amb_state;
        logic coarse_used;
        logic [7:0] gain_used;
        logic [19:0] amb_pre;
        logic [7:0] amb_step;
        logic [15:0] amb_acc;
        lpm_prox_state_type prox_state;
        logic [19:0] prox_cnt;
        logic [15:0] amb_res;
        logic [7:0] high_shadow;
        logic [7:0] prox_res;
        logic [7:0] rdata;
        logic common_on;
        logic int_o;
        logic int_oe_n;
    } lpm_state_type;

endpackage

/* lpm_log_encode.sv */
// Logarithmic 8-bit coding of a raw proximity sample
`timescale 1ns/1ns
module lpm_log_encode
    import lpm_pkg::*;
(
    input wire logic [15:0] raw,
    output logic [7:0] code
);

    logic [3:0] msb_pos;
    logic [15:0] norm;

    // Upper nibble is the exponent, lower nibble the four bits after the leading one
    always_comb
    begin
        msb_pos = 4'h0;
        for (int i = 0; i < 16; i++)
        begin
            if (raw[i])
            begin
                msb_pos = 4'(i);
            end
        end
        norm = raw << (4'hF - msb_pos);
        if (raw == 16'h0000)
        begin
            code = 8'h00;
        end
        else
        begin
            code = {msb_pos, norm[14:11]};
        end
    end

endmodule

/* lpm_host_model.sv */
// Host model that drives the register port of the measurement core
`timescale 1ns/1ns
module lpm_host_model
(
    input wire logic clk,
    input wire logic [7:0] reg_rdata,
    output logic [7:0] reg_addr,
    output logic reg_wr,
    output logic [7:0] reg_wdata,
    output logic reg_rd
);
    initial
    begin
        reg_addr = 8'hFF;
        reg_wr = 1'b0;
        reg_wdata = 8'h00;
        reg_rd = 1'b0;
    end

    // One-cycle strobe; released lines show the inverse of their last value
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
        reg_wdata = ~d;
        reg_addr = ~a;
    endtask

    // Read data stands for the cycle after the strobe edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk);
        reg_rd = 1'b0;
        reg_addr = ~a;
        d = reg_rdata;
    endtask
endmodule

/* test_lpm_core.sv */
// Self-checking bench of the light and proximity measurement core
`timescale 1ns/1ns
module test_lpm_core;
    typedef struct packed {
        logic [7:0] gain;
        logic coarse;
        logic [15:0] count;
    } lpm_row_type;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic amb_pulse = 1'b1;
    logic [15:0] prox_raw = 16'h0000;
    logic int_request = 1'b0;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
    logic reg_wr, reg_rd, reg_ready, amb_front_on, prox_front_on, common_on, int_o, int_oe_n;
    logic [15:0] v;
    int num_errors = 0;
    int checked = 0;
    int cycles = 0;
    int len;
    // Window length equals count because the pulse input is held high
    lpm_row_type rows [7] = '{{8'h35, 1'b0, 16'h00D4}, {8'h35, 1'b1, 16'h006A},
        {8'h18, 1'b1, 16'h0030}, {8'h6A, 1'b0, 16'h01A8}, {8'h10, 1'b0, 16'h0060},
        {8'hFE, 1'b0, 16'h03F8}, {8'hFF, 1'b0, 16'h03F8}};
    logic [7:0] def_a [9] = '{8'h40, 8'h45, 8'h46, 8'h52, 8'h5A, 8'h4C, 8'h4D, 8'h4F, 8'h60};
    logic [7:0] def_v [9] = '{8'h00, 8'h32, 8'h0A, 8'h08, 8'h35, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [15:0] raws [6] = '{16'h0000, 16'h0003, 16'h0013, 16'h1234, 16'h8000, 16'hFFFF};

    always #5 clk = ~clk;

    lpm_core #(.FINE_UNIT_CYCLES(4), .COARSE_UNIT_CYCLES(2), .PROX_ACTIVE_CYCLES(5),
        .POR_WAIT_CYCLES(8), .REPEAT_TICK_CYCLES(4)) lpm_core_i (.clk(clk), .resetn(resetn),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .reg_ready(reg_ready), .amb_pulse(amb_pulse),
        .amb_front_on(amb_front_on), .prox_raw(prox_raw), .prox_front_on(prox_front_on),
        .common_on(common_on), .int_request(int_request), .int_o(int_o), .int_oe_n(int_oe_n));

    lpm_host_model lpm_host_model_i (.clk(clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd));

    task automatic end_sim();
        $display("checks %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic rd16(output logic [15:0] r);
        logic [7:0] lo, hi;
        lpm_host_model_i.rd(8'h4C, lo);
        lpm_host_model_i.rd(8'h4D, hi);
        r = {hi, lo};
    endtask

    // Lets a running window pass, waits for the next to open, then counts its cycles
    task automatic window(input bit prox, output int n);
        n = 0;
        for (int i = 0; i < 2000 && (prox ? prox_front_on : amb_front_on) === 1'b1; i++)
            @(negedge clk);
        for (int i = 0; i < 2000 && (prox ? prox_front_on : amb_front_on) !== 1'b1; i++)
            @(negedge clk);
        while ((prox ? prox_front_on : amb_front_on) === 1'b1 && n < 2000)
        begin
            @(negedge clk);
            n++;
        end
    endtask

    task automatic amb_shot(input logic [7:0] gain, input logic coarse);
        lpm_host_model_i.wr(8'h40, 8'h00);
        lpm_host_model_i.wr(8'h5A, gain); // Gain changed only while powered down
        lpm_host_model_i.wr(8'h40, {4'h0, coarse, 3'h5});
        repeat (20) @(negedge clk);
        chk("forced idle window", amb_front_on, 16'h0000);
        chk("forced idle common", common_on, 16'h0001);
        lpm_host_model_i.rd(8'h41, d);
        chk("forced idle status", d, 16'h0004);
        lpm_host_model_i.wr(8'h40, {4'h1, coarse, 3'h5});
    endtask

    function automatic logic [7:0] log_code(input logic [15:0] raw);
        logic [7:0] c;
        logic [19:0] t;
        c = 8'h00;
        // Bits below the leading one, padded with zeros past bit 0
        for (int b = 0; b < 16; b++)
            if (raw[b])
            begin
                t = {raw, 4'h0} >> b;
                c = {b[3:0], t[3:0]};
            end
        return c;
    endfunction

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            num_errors++;
            end_sim();
        end
    end

    initial
    begin
        repeat (16) @(negedge clk);
        chk("ready in reset", reg_ready, 16'h0000);
        chk("pin at power-up", int_oe_n, 16'h0001);
        resetn = 1'b1;
        lpm_host_model_i.wr(8'h5A, 8'h40);
        lpm_host_model_i.rd(8'h5A, d);
        chk("read before ready", d, 16'h0000);
        repeat (2) @(negedge clk);
        chk("ready early", reg_ready, 16'h0000);
        repeat (3) @(negedge clk);
        chk("ready late", reg_ready, 16'h0001);
        foreach (def_a[i])
        begin
            lpm_host_model_i.rd(def_a[i], d);
            chk("default", d, {8'h00, def_v[i]});
        end
        lpm_host_model_i.wr(8'h4F, 8'h55);
        lpm_host_model_i.rd(8'h4F, d);
        chk("result read-only", d, 16'h0000);
        int_request = 1'b1;
        repeat (3) @(negedge clk);
        chk("pin unconfigured", int_oe_n, 16'h0001);
        lpm_host_model_i.wr(8'h52, 8'h09);
        @(negedge clk);
        chk("pin configured", int_oe_n, 16'h0000);
        chk("pin value", int_o, 16'h0000);
        int_request = 1'b0;
        foreach (rows[i])
        begin
            amb_shot(rows[i].gain, rows[i].coarse);
            window(1'b0, len);
            chk("window length", len[15:0], rows[i].count);
            rd16(v);
            chk("ambient count", v, rows[i].count);
            lpm_host_model_i.rd(8'h5A, d);
            chk("gain stored", d, {8'h00, rows[i].gain});
            chk("prox idle", prox_front_on, 16'h0000);
        end
        lpm_host_model_i.rd(8'h4C, d);
        chk("frozen low", d, 16'h00F8);
        amb_shot(8'h35, 1'b0);
        window(1'b0, len);
        lpm_host_model_i.rd(8'h4D, d);
        chk("frozen high", d, 16'h0003);
        rd16(v);
        chk("new pair", v, 16'h00D4);
        amb_pulse = 1'b0;
        amb_shot(8'h18, 1'b1);
        window(1'b0, len);
        rd16(v);
        chk("count without pulses", v, 16'h0000);
        amb_pulse = 1'b1;
        foreach (raws[i])
        begin
            prox_raw = raws[i];
            lpm_host_model_i.wr(8'h40, 8'h06);
            lpm_host_model_i.wr(8'h40, 8'h26);
            window(1'b1, len);
            chk("prox window", len[15:0], 16'h0005);
            lpm_host_model_i.rd(8'h4F, d);
            chk("prox code", d, {8'h00, log_code(raws[i])});
            chk("ambient idle", amb_front_on, 16'h0000);
        end
        lpm_host_model_i.wr(8'h40, 8'h00);
        lpm_host_model_i.wr(8'h5A, 8'h18); // Gain changed only while powered down
        lpm_host_model_i.wr(8'h45, 8'h01);
        lpm_host_model_i.wr(8'h46, 8'h01);
        lpm_host_model_i.wr(8'h40, 8'h0B);
        window(1'b0, len);
        chk("repeat window", len[15:0], 16'h0030);
        @(negedge clk);
        chk("overdue restart", amb_front_on, 16'h0001);
        window(1'b1, len);
        chk("prox alongside", len[15:0], 16'h0005);
        // Reset in mid-run while both channels repeat
        resetn = 1'b0;
        repeat (2) @(negedge clk);
        chk("reset window", amb_front_on, 16'h0000);
        chk("reset prox", prox_front_on, 16'h0000);
        chk("reset common", common_on, 16'h0000);
        chk("reset ready", reg_ready, 16'h0000);
        resetn = 1'b1;
        repeat (10) @(negedge clk);
        chk("ready after reset", reg_ready, 16'h0001);
        lpm_host_model_i.rd(8'h5A, d);
        chk("gain after reset", d, 16'h0035);
        lpm_host_model_i.rd(8'h40, d);
        chk("ctrl after reset", d, 16'h0000);
        lpm_host_model_i.rd(8'h45, d);
        chk("rate after reset", d, 16'h0032);
        end_sim();
    end
endmodule
